// *** rtl/output_driver_serial_control.sv ***
// Serial frame receiver, mode strap and output drive state of the driver.
// Assumes the serial clock and all pins are asynchronous to clock; the
// serial clock must stay well below a quarter of the system clock rate.
module output_driver_serial_control (
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              sclk,
   input  wire logic              sdin,
   input  wire logic              latch_n,
   input  wire logic              clear_in,
   input  wire logic              clear_level_select,
   input  wire logic              control_source_select,
   input  wire logic              frame_checksum_mode,
   input  wire logic              bus_slot_bit0,
   input  wire logic              bus_slot_bit1,
   input  wire logic              bus_slot_bit2,
   input  wire logic [2:0]        hw_range,
   input  wire logic              hw_overrange,
   input  wire logic              open_circuit,
   input  wire logic              short_circuit,
   input  wire logic              over_temp,
   output logic                   alarm_o,
   output logic                   alarm_oe_n,
   output logic                   checksum_error,
   output logic                   hw_mode,
   output odsc_pkg::drive_s       drive
);
   odsc_pkg::pins_s  raw, s1_q, s1_d, p, s2_d;
   logic             sclk_prev_q, sclk_prev_d, latch_prev_q, latch_prev_d;
   logic [23:0]      shreg_q, shreg_d;
   logic [4:0]       cnt_q, cnt_d;
   logic [7:0]       crc_q, crc_d;
   odsc_pkg::boot_e  boot_q, boot_d;
   logic             hw_q, hw_d, loaded_q, loaded_d, crc_err_q, crc_err_d;
   logic             alarm_q, alarm_d;
   odsc_pkg::cfg_s   cfg_q, cfg_d, eff;
   odsc_pkg::drive_s drive_q, drive_d;
   logic             fall, rise, len_ok, crc_ok, addr_ok, rng_ok;
   logic [15:0]      data;
   logic [4:0]       want;
   logic             clr_act, csel;

   // One step of CRC-8, polynomial x^8+x^2+x+1, MSB first.
   function automatic logic [7:0] crc_step(input logic [7:0] c,
                                           input logic b);
      logic fb;
      fb = c[7] ^ b;
      crc_step = {c[6:0], 1'b0} ^ (fb ? odsc_pkg::CRC_POLY : 8'h00);
   endfunction

   // Pins gathered into one carrier so the whole set is synchronised alike.
   // The serial port has clock, data and strobe only, no readback.
   always_comb begin
      raw = '{sclk, sdin, latch_n, clear_in, clear_level_select,
              open_circuit, short_circuit, over_temp,
              control_source_select, frame_checksum_mode,
              {bus_slot_bit2, bus_slot_bit1, bus_slot_bit0},
              hw_range, hw_overrange};
      s1_d = raw;
      s2_d = s1_q;
   end

   // Frame decode helpers read only the second synchroniser stage.
   always_comb begin
      fall    = sclk_prev_q & ~p.sclk;
      rise    = ~latch_prev_q & p.latch_n;
      want    = p.frame_checksum_mode ? odsc_pkg::FRAME_CRC_BITS
                                      : odsc_pkg::FRAME_BITS;
      data    = p.frame_checksum_mode ? shreg_q[23:8] : shreg_q[15:0];
      len_ok  = (cnt_q == want);
      crc_ok  = ~p.frame_checksum_mode | (shreg_q[7:0] == crc_q);
      addr_ok = (data[odsc_pkg::SLOT_MSB:odsc_pkg::SLOT_LSB] == p.slot);
      rng_ok  = (data[odsc_pkg::RANGE_MSB:odsc_pkg::RANGE_LSB]
                 <= odsc_pkg::RNG_I420);
   end

   // Next state of the receiver, mode strap, configuration and outputs.
   always_comb begin
      sclk_prev_d  = p.sclk;
      latch_prev_d = p.latch_n;
      shreg_d      = shreg_q;
      cnt_d        = cnt_q;
      crc_d        = crc_q;
      boot_d       = boot_q;
      hw_d         = hw_q;
      loaded_d     = loaded_q;
      crc_err_d    = crc_err_q;
      cfg_d        = cfg_q;
      // Strobe high: arm for the next frame. MSB arrives first.
      if (p.latch_n) begin
         cnt_d = 5'h00;
         crc_d = odsc_pkg::CRC_INIT;
      end else if (fall && cnt_q < odsc_pkg::FRAME_CRC_BITS) begin
         shreg_d = {shreg_q[22:0], p.sdin};
         cnt_d   = cnt_q + 5'h01;
         if (cnt_q < odsc_pkg::FRAME_BITS) begin
            crc_d = crc_step(crc_q, p.sdin);
         end
      end
      // The strap is taken once the synchroniser holds a settled level.
      case (boot_q)
         odsc_pkg::boot_wait0: boot_d = odsc_pkg::boot_wait1;
         odsc_pkg::boot_wait1: boot_d = odsc_pkg::boot_sample;
         odsc_pkg::boot_sample: begin
            boot_d = odsc_pkg::boot_run;
            hw_d   = p.control_source_select;
            // In software mode, clear high at power-up floats the voltage output.
            cfg_d.vout_en = ~p.clear;
         end
         default: boot_d = odsc_pkg::boot_run;
      endcase
      // A frame counts only when complete, checked and addressed here.
      if (boot_q == odsc_pkg::boot_run && !hw_q && rise && len_ok) begin
         if (!crc_ok) begin
            crc_err_d = 1'b1;
         end else if (addr_ok && rng_ok) begin
            crc_err_d       = 1'b0;
            loaded_d        = 1'b1;
            cfg_d.range_sel = data[odsc_pkg::RANGE_MSB:odsc_pkg::RANGE_LSB];
            cfg_d.overrange = data[odsc_pkg::OVR_BIT];
            cfg_d.vout_en   = data[odsc_pkg::VEN_BIT];
            cfg_d.soft_clear = data[odsc_pkg::SCLR_BIT];
            cfg_d.clear_sel = data[odsc_pkg::CSEL_BIT];
         end
      end
   end

   // Effective settings: pins in hardware mode, frames in software mode.
   always_comb begin
      eff = cfg_q;
      if (hw_q) begin
         eff = '{p.hw_range, p.hw_overrange, 1'b1, 1'b0, 1'b0};
         // An undefined pin code keeps the range already driven, so the
         // output never leaves the documented set of ranges.
         if (p.hw_range > odsc_pkg::RNG_I420) begin
            eff.range_sel = drive_q.range_sel;
         end
      end
      clr_act = p.clear | eff.soft_clear;
      csel    = p.clear_level_select | eff.clear_sel;
      drive_d = drive_q;
      alarm_d = 1'b0;
      if (boot_q == odsc_pkg::boot_run) begin
         drive_d.range_sel  = eff.range_sel;
         drive_d.overrange  = eff.overrange;
         drive_d.is_current = (eff.range_sel >= odsc_pkg::RNG_I20);
         drive_d.vout_hiz   = ~eff.vout_en;
         // Clear overrides the frame without waiting for a latch.
         if (clr_act) begin
            drive_d.level = drive_d.is_current ? odsc_pkg::level_low_end :
                            csel ? odsc_pkg::level_mid : odsc_pkg::level_zero;
         end else if (!hw_q && !loaded_q) begin
            drive_d.level = odsc_pkg::level_zero;
         end else begin
            drive_d.level = odsc_pkg::level_normal;
         end
         alarm_d = ~hw_q & (p.open_circuit | p.short_circuit |
                            p.over_temp | crc_err_q);
      end
   end

   // All state; the first stage of the synchroniser feeds only the second.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s1_q         <= '0;
         p            <= '0;
         sclk_prev_q  <= 1'b0;
         latch_prev_q <= 1'b1;
         shreg_q      <= '0;
         cnt_q        <= 5'h00;
         crc_q        <= odsc_pkg::CRC_INIT;
         boot_q       <= odsc_pkg::boot_wait0;
         hw_q         <= 1'b0;
         loaded_q     <= 1'b0;
         crc_err_q    <= 1'b0;
         alarm_q      <= 1'b0;
         cfg_q        <= odsc_pkg::CFG_RESET;
         drive_q      <= odsc_pkg::DRIVE_RESET;
      end else begin
         s1_q         <= s1_d;
         p            <= s2_d;
         sclk_prev_q  <= sclk_prev_d;
         latch_prev_q <= latch_prev_d;
         shreg_q      <= shreg_d;
         cnt_q        <= cnt_d;
         crc_q        <= crc_d;
         boot_q       <= boot_d;
         hw_q         <= hw_d;
         loaded_q     <= loaded_d;
         crc_err_q    <= crc_err_d;
         alarm_q      <= alarm_d;
         cfg_q        <= cfg_d;
         drive_q      <= drive_d;
      end
   end

   // Open-drain alarm: the pin level is always low, only the enable moves.
   assign alarm_o        = 1'b0;
   assign alarm_oe_n     = ~alarm_q;
   assign checksum_error = crc_err_q;
   assign hw_mode        = hw_q;
   assign drive          = drive_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   logic run_sw;
   assign run_sw = (boot_q == odsc_pkg::boot_run) && !hw_q;

   sequence bad_crc_frame;
      run_sw && rise && len_ok && !crc_ok;
   endsequence
   sequence good_frame;
      run_sw && rise && len_ok && crc_ok && addr_ok && rng_ok;
   endsequence

   a_crc_reject: assert property (
      bad_crc_frame |=> $stable(cfg_q) && crc_err_q ##1 !alarm_oe_n)
      else $error("Bad checksum frame changed the settings.");
   a_len_reject: assert property (
      run_sw && rise && !len_ok |=> $stable(cfg_q))
      else $error("Frame of wrong length was taken.");
   a_slot_filter: assert property (
      run_sw && rise && len_ok && crc_ok && !addr_ok |=> $stable(cfg_q))
      else $error("Frame for another slot was taken.");
   a_latch_update: assert property (
      good_frame |=> cfg_q.range_sel ==
      $past(data[odsc_pkg::RANGE_MSB:odsc_pkg::RANGE_LSB])
      ##1 drive_q.range_sel == cfg_q.range_sel)
      else $error("Latched frame did not reach the output.");
   a_clear_current: assert property (
      boot_q == odsc_pkg::boot_run && p.clear
      && eff.range_sel >= odsc_pkg::RNG_I20
      |=> drive_q.level == odsc_pkg::level_low_end)
      else $error("Clear did not force current low end.");
   a_clear_mid: assert property (
      boot_q == odsc_pkg::boot_run && p.clear
      && p.clear_level_select && eff.range_sel < odsc_pkg::RNG_I20
      |=> drive_q.level == odsc_pkg::level_mid)
      else $error("Clear select did not give midscale.");
   a_range_legal: assert property (
      drive_q.range_sel <= odsc_pkg::RNG_I420)
      else $error("Output range code out of set.");
   a_mode_hold: assert property (
      boot_q == odsc_pkg::boot_run |=> $stable(hw_q))
      else $error("Control source changed after power-up.");
   a_alarm_fault: assert property (
      run_sw && (p.open_circuit | p.short_circuit | p.over_temp)
      |-> ##[1:2] !alarm_oe_n)
      else $error("Fault did not pull the alarm low.");
   a_power_zero: assert property (
      run_sw && !loaded_q && !clr_act
      |=> drive_q.level == odsc_pkg::level_zero)
      else $error("Output left zero before the first frame.");
endmodule

// *** rtl/odsc_pkg.sv ***
// Constants, field layout and carrier types for the output driver control.
// Assumes one 100 MHz clock domain; every pin is synchronised before use.
package odsc_pkg;
   localparam logic [4:0] FRAME_BITS     = 5'h10;
   localparam logic [4:0] FRAME_CRC_BITS = 5'h18;
   localparam logic [7:0] CRC_POLY       = 8'h07;
   localparam logic [7:0] CRC_INIT       = 8'h00;
   // Data word layout.
   localparam int SLOT_MSB  = 15;
   localparam int SLOT_LSB  = 13;
   localparam int RANGE_MSB = 12;
   localparam int RANGE_LSB = 10;
   localparam int OVR_BIT   = 9;
   localparam int VEN_BIT   = 8;
   localparam int SCLR_BIT  = 7;
   localparam int CSEL_BIT  = 6;
   // Range codes; codes above the last current range are invalid.
   localparam logic [2:0] RNG_V5   = 3'h0;
   localparam logic [2:0] RNG_V10  = 3'h1;
   localparam logic [2:0] RNG_V40  = 3'h2;
   localparam logic [2:0] RNG_I20  = 3'h3;
   localparam logic [2:0] RNG_I24  = 3'h4;
   localparam logic [2:0] RNG_I420 = 3'h5;

   typedef enum logic [1:0] {level_normal, level_zero, level_mid,
                             level_low_end} level_e;
   typedef enum logic [1:0] {boot_wait0, boot_wait1, boot_sample,
                             boot_run} boot_e;

   typedef struct packed {
      logic       sclk;
      logic       sdin;
      logic       latch_n;
      logic       clear;
      logic       clear_level_select;
      logic       open_circuit;
      logic       short_circuit;
      logic       over_temp;
      logic       control_source_select;
      logic       frame_checksum_mode;
      logic [2:0] slot;
      logic [2:0] hw_range;
      logic       hw_overrange;
   } pins_s;

   typedef struct packed {
      logic [2:0] range_sel;
      logic       overrange;
      logic       vout_en;
      logic       soft_clear;
      logic       clear_sel;
   } cfg_s;

   typedef struct packed {
      logic [2:0] range_sel;
      logic       overrange;
      logic       is_current;
      logic       vout_hiz;
      level_e     level;
   } drive_s;

   localparam cfg_s   CFG_RESET   = '{RNG_V5, 1'b0, 1'b1, 1'b0, 1'b0};
   localparam drive_s DRIVE_RESET = '{RNG_V5, 1'b0, 1'b0, 1'b0, level_zero};
endpackage

// *** verif/host_frame_model.sv ***
// Host model that shifts write frames into the driver's serial port.
// Assumes the caller starts a frame just after a system clock edge.
module host_frame_model (
   output logic sclk,
   output logic sdin,
   output logic latch_n
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam time HALF = 40ns;

   // Idle link: clock parked high and strobe high between frames.
   initial begin
      sclk    = 1'b1;
      sdin    = 1'b0;
      latch_n = 1'b1;
   end

   // Sends n bits of a left-aligned word; data changes while the clock
   // is high, so it is settled long before each falling edge.
   task automatic send(input logic [23:0] word, input int n);
      latch_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdin = word[23-i];
         #HALF sclk = 1'b0;
         #HALF sclk = 1'b1;
      end
      #HALF latch_n = 1'b1;
      sdin = ~sdin; // A released line must not keep showing the last bit.
      #(2*HALF);
   endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the output driver serial control block.
// Assumes the design package is compiled first; a host model drives frames.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic             clock = 1'b0;
   logic             nrst = 1'b0;
   logic             sclk, sdin, latch_n, clear_in, clear_level_select;
   logic             control_source_select, frame_checksum_mode;
   logic             hw_overrange, open_circuit, short_circuit, over_temp;
   logic             alarm_o, alarm_oe_n, checksum_error, hw_mode;
   logic [2:0]       slot = 3'h5;
   logic [2:0]       hw_range = 3'h4;
   logic [15:0]      w;
   odsc_pkg::drive_s drive;
   int               err_count = 0;
   int               checks = 0;
   logic [7:0]       flags;
   localparam odsc_pkg::level_e NRM = odsc_pkg::level_normal;
   localparam odsc_pkg::level_e MID = odsc_pkg::level_mid;

   // Status pins packed into one byte so one compare covers both.
   assign flags = {6'h0, checksum_error, alarm_oe_n};

   // Free-running 100 MHz system clock.
   always #5 clock = ~clock;

   host_frame_model host (.sclk(sclk), .sdin(sdin), .latch_n(latch_n));

   output_driver_serial_control dut (
      .clock(clock), .nrst(nrst), .sclk(sclk), .sdin(sdin),
      .latch_n(latch_n), .clear_in(clear_in),
      .clear_level_select(clear_level_select),
      .control_source_select(control_source_select),
      .frame_checksum_mode(frame_checksum_mode),
      .bus_slot_bit0(slot[0]), .bus_slot_bit1(slot[1]),
      .bus_slot_bit2(slot[2]), .hw_range(hw_range),
      .hw_overrange(hw_overrange), .open_circuit(open_circuit),
      .short_circuit(short_circuit), .over_temp(over_temp),
      .alarm_o(alarm_o), .alarm_oe_n(alarm_oe_n),
      .checksum_error(checksum_error), .hw_mode(hw_mode), .drive(drive));

   // Helpers: cycle wait landing 1 ns past the edge, compare, frame build.
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bit-serial CRC, MSB first; kept separate from the design's own code.
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   function automatic logic [15:0] wd(input logic [2:0] sl, rg,
                                      input logic ov, ve, sc, cs);
      return {sl, rg, ov, ve, sc, cs, 6'h00};
   endfunction
   function automatic odsc_pkg::drive_s ex(input logic [2:0] rg,
                                           input logic ov,
                                           input odsc_pkg::level_e lv);
      return '{rg, ov, rg >= 3'h3, 1'b0, lv};
   endfunction
   // Eight more cycles after the host's trailing wait cover the four-cycle load path.
   task automatic frame(input logic [15:0] d, input int n = 16,
                        input logic [7:0] c = 8'h00);
      host.send({d, c}, n);
      cyc(8);
   endtask
   task automatic boot(input logic cs, input logic clr);
      nrst = 1'b0;
      control_source_select = cs;
      clear_in = clr;
      cyc(6);
      chk("reset_drive", odsc_pkg::DRIVE_RESET, drive);
      nrst = 1'b1;
      cyc(6);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence: software mode, refusals, clear, faults, checksum, pins.
   initial begin
      {clear_level_select, frame_checksum_mode, hw_overrange} = 3'h0;
      {open_circuit, short_circuit, over_temp} = 3'h0;
      boot(1'b0, 1'b1);
      chk("hw_mode_sw", 8'h00, {7'h0, hw_mode});
      chk("power_up_hiz", 8'h01, {7'h0, drive.vout_hiz});
      clear_in = 1'b0;
      for (int r = 0; r < 6; r++) begin
         frame(wd(slot, r[2:0], r < 3, 1'b1, 1'b0, 1'b0));
         chk("range", ex(r[2:0], r < 3, NRM), drive);
      end
      frame(wd(slot ^ 3'h1, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0));
      chk("wrong_slot", ex(3'h5, 1'b0, NRM), drive);
      frame(wd(slot, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0), 15);
      chk("short_frame", ex(3'h5, 1'b0, NRM), drive);
      frame(wd(slot, 3'h6, 1'b0, 1'b1, 1'b0, 1'b0));
      chk("bad_code", ex(3'h5, 1'b0, NRM), drive);
      clear_in = 1'b1;
      cyc(5);
      chk("clr_cur", ex(3'h5, 1'b0, odsc_pkg::level_low_end), drive);
      clear_in = 1'b0;
      frame(wd(slot, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0));
      clear_level_select = 1'b1;
      clear_in = 1'b1;
      cyc(5);
      chk("clr_mid", ex(3'h1, 1'b0, MID), drive);
      {clear_in, clear_level_select} = 2'h0;
      frame(wd(slot, 3'h1, 1'b0, 1'b1, 1'b1, 1'b1));
      chk("soft_mid", ex(3'h1, 1'b0, odsc_pkg::level_mid), drive);
      frame(wd(slot, 3'h1, 1'b0, 1'b1, 1'b1, 1'b0));
      chk("soft_zero", ex(3'h1, 1'b0, odsc_pkg::level_zero), drive);
      for (int f = 0; f < 3; f++) begin
         {open_circuit, short_circuit, over_temp} = 3'h4 >> f;
         cyc(4);
         chk("fault_alarm", 8'h00, {7'h0, alarm_oe_n | alarm_o});
         {open_circuit, short_circuit, over_temp} = 3'h0;
         cyc(4);
         chk("alarm_idle", 8'h01, {7'h0, alarm_oe_n});
      end
      frame_checksum_mode = 1'b1;
      w = wd(slot, 3'h2, 1'b1, 1'b1, 1'b0, 1'b0);
      frame(w, 24, crc8(w));
      chk("crc_good", ex(3'h2, 1'b1, odsc_pkg::level_normal), drive);
      w = wd(slot, 3'h4, 1'b0, 1'b1, 1'b0, 1'b0);
      frame(w, 24, crc8(w) ^ 8'h01);
      chk("crc_bad", ex(3'h2, 1'b1, odsc_pkg::level_normal), drive);
      chk("crc_flag", 8'h02, flags);
      frame(w, 16);
      chk("pec_short", ex(3'h2, 1'b1, odsc_pkg::level_normal), drive);
      frame(w, 24, crc8(w));
      chk("crc_clear", 8'h01, {6'h0, checksum_error, alarm_oe_n});
      frame_checksum_mode = 1'b0;
      boot(1'b1, 1'b0);
      chk("hw_mode_hw", 8'h01, {7'h0, hw_mode});
      frame(wd(slot, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0));
      chk("hw_range", 8'h04, {5'h0, drive.range_sel});
      // An undefined pin code must leave the driven range as it was.
      hw_range = 3'h7;
      hw_overrange = 1'b1;
      cyc(5);
      chk("hw_bad_pin", ex(3'h4, 1'b1, NRM), drive);
      over_temp = 1'b1;
      cyc(4);
      chk("hw_no_alarm", 8'h01, {7'h0, alarm_oe_n});
      stop_test();
   end

   // Watchdog: the sequence needs well under 100 us.
   initial begin
      #500us;
      err_count++;
      stop_test();
   end
endmodule
